// *** hw/prxs_fifo.sv ***
// Valid/ready FIFO with parameterised width and depth
module prxs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic [WIDTH-1:0]      o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          rdy;
   } prxs_fifo_s;

   // Ready is a flop of its own so the accept output has no logic behind it
   localparam prxs_fifo_s RST_ST = '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};

   prxs_fifo_s          st_r;
   prxs_fifo_s          st_nxt;
   logic [WIDTH-1:0]    mem [DEPTH];
   logic                push;
   logic                pop;

   assign o_ready = st_r.rdy;
   assign o_valid = (st_r.cnt != '0);
   assign o_data  = mem[st_r.rp];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      st_nxt.rdy = (st_nxt.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= RST_ST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Storage needs no reset; only the pointers and the count qualify it
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[st_r.wp] <= i_data;
      end
   end
endmodule

// *** hw/prxs_port.sv ***
// Receive packet stream port: forwards words lane for lane, marks and buffers packets toward the application
module prxs_port #(
   parameter int DATA_W = prxs_pkg::DATA_W_DEFAULT,
   parameter int DEPTH  = prxs_pkg::FIFO_DEPTH
) (
   input  wire logic                        I_CLOCK,
   input  wire logic                        I_RSTN,
   // Transaction-layer side: one word per beat, header dwords first
   input  wire logic [DATA_W-1:0]           I_TL_WORD,
   input  wire logic                        I_TL_VALID,
   input  wire logic                        I_TL_FIRST,
   input  wire logic                        I_TL_LAST,
   input  wire logic [DATA_W/8-1:0]         I_TL_PAYLOAD_BYTES,
   input  wire logic                        I_TL_UPPER_EMPTY,
   input  wire logic [prxs_pkg::HIT_W-1:0]  I_TL_HIT,
   input  wire logic [prxs_pkg::FUNC_W-1:0] I_TL_FUNC,
   output logic                             O_TL_ACCEPT,
   // Application side
   output logic [DATA_W-1:0]                O_RX_PAYLOAD_WORD,
   output logic                             O_RX_SOURCE_VALID,
   output logic                             O_RX_FIRST_BEAT,
   output logic                             O_RX_LAST_BEAT,
   output logic [DATA_W/8-1:0]              O_RX_LANE_ENABLES,
   output logic                             O_RX_UPPER_HALF_UNUSED,
   output logic [prxs_pkg::HIT_W-1:0]       O_RX_WINDOW_HIT_VECTOR,
   output logic [prxs_pkg::FUNC_W-1:0]      O_RX_FUNC_INDEX,
   input  wire logic                        I_RX_SINK_ACCEPT
);
   localparam int BE_W = DATA_W/8;
   localparam int FW   = DATA_W + BE_W + 3 + prxs_pkg::HIT_W + prxs_pkg::FUNC_W;

   typedef enum logic [1:0] {
      PRXS_EMPTY = 2'b00,
      PRXS_FULL  = 2'b01
   } prxs_out_e;

   typedef struct packed {
      prxs_out_e                     ost;
      logic [DATA_W-1:0]             word;
      logic                          first;
      logic                          last;
      logic [BE_W-1:0]               be;
      logic                          empty;
      logic [prxs_pkg::HIT_W-1:0]    hit;
      logic [prxs_pkg::FUNC_W-1:0]   func;
      logic                          vld;
      logic                          o_first;
      logic                          o_last;
      logic [BE_W-1:0]               o_be;
      logic                          o_empty;
   } prxs_port_s;

   ////////////////////////////////////////////////////////////////////////////
   // Incoming beat conditioning

   logic [FW-1:0]               in_flat;
   logic [FW-1:0]               out_flat;
   logic                        fifo_valid;
   logic                        fifo_take;
   logic [BE_W-1:0]             in_be;
   logic                        in_empty;
   logic [prxs_pkg::HIT_W-1:0]  in_hit;
   logic [prxs_pkg::FUNC_W-1:0] in_func;

   // Enables only where payload bytes hold data; header lanes arrive zero
   always_comb begin
      in_be    = I_TL_PAYLOAD_BYTES;
      // Empty flag only exists on the wide bus and only on a last beat
      in_empty = (DATA_W > prxs_pkg::HALF_W) && I_TL_LAST && I_TL_UPPER_EMPTY;
      // Hit vector and function index qualified to the first beat
      in_hit   = I_TL_FIRST ? I_TL_HIT : '0;
      in_func  = I_TL_FIRST ? I_TL_FUNC : '0;
   end

   // Word is forwarded lane for lane: byte 0 in bits 7:0 keeps little-endian
   // order, and a 3-dword header at addr[2]=1 already lands Data0 in the upper dword
   assign in_flat = {I_TL_WORD, in_be, I_TL_FIRST, I_TL_LAST, in_empty,
                     in_hit, in_func};

   ////////////////////////////////////////////////////////////////////////////
   // Buffer between the transaction layer and the output stage

   prxs_fifo #(
      .WIDTH (FW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk   (I_CLOCK),
      .i_rstn  (I_RSTN),
      .i_data  (in_flat),
      .i_valid (I_TL_VALID),
      .o_ready (O_TL_ACCEPT),
      .o_data  (out_flat),
      .o_valid (fifo_valid),
      .i_ready (fifo_take)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registered output stage

   prxs_port_s st_r;
   prxs_port_s st_nxt;
   logic       out_done;

   // Word leaves when the sink takes it; a held word never changes
   assign out_done  = st_r.vld && I_RX_SINK_ACCEPT;
   // Refill in the same cycle as a take, so packets run back to back
   assign fifo_take = fifo_valid && ((st_r.ost == PRXS_EMPTY) || out_done);

   always_comb begin
      st_nxt = st_r;
      case (st_r.ost)
         PRXS_EMPTY: begin
            if (fifo_take) begin
               st_nxt.ost = PRXS_FULL;
            end
         end
         PRXS_FULL: begin
            if (out_done && !fifo_take) begin
               st_nxt.ost = PRXS_EMPTY;
            end
         end
         default: begin
            st_nxt.ost = PRXS_EMPTY;
         end
      endcase
      if (fifo_take) begin
         // One-beat packets keep both markers from the same entry
         {st_nxt.word, st_nxt.be, st_nxt.first, st_nxt.last, st_nxt.empty,
          st_nxt.hit, st_nxt.func} = out_flat;
      end else if (out_done) begin
         // Markers cleared with valid so idle cycles show nothing stale
         st_nxt.first = 1'b0;
         st_nxt.last  = 1'b0;
         st_nxt.be    = '0;
         st_nxt.empty = 1'b0;
      end
      // Valid follows accept one cycle late; a pending word stays parked
      st_nxt.vld     = (st_nxt.ost == PRXS_FULL) && I_RX_SINK_ACCEPT;
      st_nxt.o_first = st_nxt.vld && st_nxt.first;
      st_nxt.o_last  = st_nxt.vld && st_nxt.last;
      st_nxt.o_be    = st_nxt.vld ? st_nxt.be : '0;
      st_nxt.o_empty = st_nxt.vld && st_nxt.empty;
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output ports, straight from the stage registers

   // Valid drops one cycle after accept drops; the word itself is held
   assign O_RX_SOURCE_VALID      = st_r.vld;
   assign O_RX_PAYLOAD_WORD      = st_r.word;
   assign O_RX_FIRST_BEAT        = st_r.o_first;
   assign O_RX_LAST_BEAT         = st_r.o_last;
   assign O_RX_LANE_ENABLES      = st_r.o_be;
   assign O_RX_UPPER_HALF_UNUSED = st_r.o_empty;
   assign O_RX_WINDOW_HIT_VECTOR = st_r.hit;
   assign O_RX_FUNC_INDEX        = st_r.func;
endmodule

// *** inc/prxs_pkg.sv ***
// Shared constants for the receive packet stream port
package prxs_pkg;
   localparam int DATA_W_DEFAULT  = 64;
   localparam int FIFO_DEPTH      = 32;
   localparam int HIT_W           = 8;
   localparam int FUNC_W          = 3;
   localparam int HALF_W          = 64;
   // Root-port hit vector bit positions
   localparam int HIT_BAR0        = 0;
   localparam int HIT_BAR1        = 1;
   localparam int HIT_PRI_BUS     = 2;
   localparam int HIT_SEC_BUS     = 3;
   localparam int HIT_SUB_RANGE   = 4;
   localparam int HIT_IO_WIN      = 5;
   localparam int HIT_NONPREF_WIN = 6;
   localparam int HIT_PREF_WIN    = 7;
   localparam logic [1:0] RST_ZERO2 = 2'h0;
endpackage

// *** verification/prxs_app_sink.sv ***
// Application sink model: random accept, or none while told to stall
module prxs_app_sink (
   input  wire logic i_clk,
   input  wire logic i_stall,
   output logic      o_accept
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 62836;
   initial o_accept = 1'b0;
   // Lane enables unused; takes back-to-back packets as offered
   always @(negedge i_clk) o_accept <= !i_stall && ($random(seed) % 4 != 0);
endmodule

// *** verification/prxs_port_sva.sv ***
// Concurrent checks on the receive stream port outputs
module prxs_port_sva #(
   parameter int DATA_W = 64,
   parameter int DEPTH  = 32
) (
   input wire logic                        I_CLOCK,
   input wire logic                        I_RSTN,
   input wire logic                        I_TL_VALID,
   input wire logic                        O_TL_ACCEPT,
   input wire logic [DATA_W-1:0]           O_RX_PAYLOAD_WORD,
   input wire logic                        O_RX_SOURCE_VALID,
   input wire logic                        O_RX_FIRST_BEAT,
   input wire logic                        O_RX_LAST_BEAT,
   input wire logic [DATA_W/8-1:0]         O_RX_LANE_ENABLES,
   input wire logic                        O_RX_UPPER_HALF_UNUSED,
   input wire logic [prxs_pkg::HIT_W-1:0]  O_RX_WINDOW_HIT_VECTOR,
   input wire logic [prxs_pkg::FUNC_W-1:0] O_RX_FUNC_INDEX,
   input wire logic                        I_RX_SINK_ACCEPT
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RSTN);
   sequence s_stall; O_RX_SOURCE_VALID && !I_RX_SINK_ACCEPT; endsequence
   sequence s_held; !O_RX_SOURCE_VALID && $stable(O_RX_PAYLOAD_WORD); endsequence
   sequence s_resume; s_stall ##1 I_RX_SINK_ACCEPT; endsequence
   property p_hold; s_stall |=> s_held; endproperty
   property p_marks;
      s_resume |=> O_RX_SOURCE_VALID && $stable(O_RX_PAYLOAD_WORD) &&
         {O_RX_FIRST_BEAT, O_RX_LAST_BEAT, O_RX_LANE_ENABLES} ==
         $past({O_RX_FIRST_BEAT, O_RX_LAST_BEAT, O_RX_LANE_ENABLES}, 2);
   endproperty
   property p_drop; !I_RX_SINK_ACCEPT |-> ##[1:3] !O_RX_SOURCE_VALID; endproperty
   property p_hit; O_RX_SOURCE_VALID && !O_RX_FIRST_BEAT |-> O_RX_WINDOW_HIT_VECTOR == '0;
   endproperty
   property p_func; O_RX_SOURCE_VALID && !O_RX_FIRST_BEAT |-> O_RX_FUNC_INDEX == '0; endproperty
   property p_empty;
      O_RX_SOURCE_VALID && O_RX_UPPER_HALF_UNUSED |-> O_RX_LAST_BEAT && (O_RX_LANE_ENABLES >> 8) == '0;
   endproperty
   property p_full;
      O_RX_SOURCE_VALID && O_RX_LAST_BEAT && (O_RX_LANE_ENABLES >> 8) != '0 |-> !O_RX_UPPER_HALF_UNUSED;
   endproperty
   property p_idle;
      !O_RX_SOURCE_VALID |-> !O_RX_FIRST_BEAT && !O_RX_LAST_BEAT && O_RX_LANE_ENABLES == '0;
   endproperty
   property p_answer; I_TL_VALID && O_TL_ACCEPT |-> ##[2:1000] O_RX_SOURCE_VALID; endproperty
   a_hold: assert property (p_hold) else $error("word changed while stalled");
   a_marks: assert property (p_marks) else $error("markers changed while stalled");
   a_hit: assert property (p_hit) else $error("hit vector off first beat");
   a_func: assert property (p_func) else $error("function index off first beat");
   a_empty: assert property (p_empty) else $error("upper half flag misplaced");
   a_full: assert property (p_full) else $error("upper half flag with upper data");
   a_idle: assert property (p_idle) else $error("markers while idle");
   a_answer: assert property (p_answer) else $error("accepted beat never delivered");
   a_drop: assert property (p_drop) else $error("valid kept after accept fell");
endmodule
bind prxs_port prxs_port_sva #(.DATA_W(DATA_W), .DEPTH(DEPTH)) i_prxs_port_sva (
   .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_TL_VALID(I_TL_VALID), .O_TL_ACCEPT(O_TL_ACCEPT),
   .O_RX_PAYLOAD_WORD(O_RX_PAYLOAD_WORD), .O_RX_SOURCE_VALID(O_RX_SOURCE_VALID),
   .O_RX_FIRST_BEAT(O_RX_FIRST_BEAT), .O_RX_LAST_BEAT(O_RX_LAST_BEAT),
   .O_RX_LANE_ENABLES(O_RX_LANE_ENABLES), .O_RX_UPPER_HALF_UNUSED(O_RX_UPPER_HALF_UNUSED),
   .O_RX_WINDOW_HIT_VECTOR(O_RX_WINDOW_HIT_VECTOR), .O_RX_FUNC_INDEX(O_RX_FUNC_INDEX),
   .I_RX_SINK_ACCEPT(I_RX_SINK_ACCEPT));

// *** verification/tb_top.sv ***
// Self-checking bench for the receive stream port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int E = 158;
   logic clk = 0, rstn = 0, tv = 0, tf = 0, tl = 0, tue = 0, stall = 0;
   logic acc, oacc, ov, ofst, olst, oue;
   logic [127:0] tw = '0, ow;
   logic [15:0] tb = '0, obe;
   logic [7:0] th = '0, ohit;
   logic [2:0] tfn = '0, ofn;
   logic [E-1:0] q[$], exp;
   int mismatches = 0, comparisons = 0, seed = 62836, cyc = 0;
   prxs_port #(.DATA_W(128)) i_prxs_port (.I_CLOCK(clk), .I_RSTN(rstn), .I_TL_WORD(tw),
      .I_TL_VALID(tv), .I_TL_FIRST(tf), .I_TL_LAST(tl), .I_TL_PAYLOAD_BYTES(tb),
      .I_TL_UPPER_EMPTY(tue), .I_TL_HIT(th), .I_TL_FUNC(tfn), .O_TL_ACCEPT(oacc),
      .O_RX_PAYLOAD_WORD(ow), .O_RX_SOURCE_VALID(ov), .O_RX_FIRST_BEAT(ofst),
      .O_RX_LAST_BEAT(olst), .O_RX_LANE_ENABLES(obe), .O_RX_UPPER_HALF_UNUSED(oue),
      .O_RX_WINDOW_HIT_VECTOR(ohit), .O_RX_FUNC_INDEX(ofn), .I_RX_SINK_ACCEPT(acc));
   prxs_app_sink i_prxs_app_sink (.i_clk(clk), .i_stall(stall), .o_accept(acc));
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Valid stays up between beats so packets run back to back
   task automatic beat(input logic f, input logic l);
      tw = {$random(seed), $random(seed), $random(seed), $random(seed)};
      tb = 16'($random(seed));
      tue = l && ($random(seed) & 1);
      if (tue) tb[15:8] = 8'h00;
      th = 8'($random(seed));
      tfn = 3'($random(seed));
      tf = f;
      tl = l;
      tv = 1;
      while (!oacc) @(negedge clk);
      q.push_back({tw, f, l, tb, tue, f ? th : 8'h00, f ? tfn : 3'h0});
      @(negedge clk);
   endtask
   task automatic pkt(input int n);
      for (int i = 0; i < n; i++) beat(i == 0, i == n - 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) if (rstn) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
      if (ov && acc) begin
         exp = q.pop_front();
         comparisons++;
         if ({ow, ofst, olst, obe, oue, ohit, ofn} !== exp) begin
            $display("unexpected rx beat expected %h seen %h", exp,
               {ow, ofst, olst, obe, oue, ohit, ofn});
            mismatches++;
         end
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1;
      @(negedge clk);
      pkt(1);
      pkt(1);
      pkt(3);
      stall = 1;
      while (oacc) beat(1, 1);
      tv = 0;
      stall = 0;
      repeat (300) pkt(1 + $unsigned($random(seed)) % 4);
      tv = 0;
      repeat (400) @(negedge clk);
      comparisons++;
      if (q.size() != 0) begin
         $display("unexpected pending beats expected 0 seen %0d", q.size());
         mismatches++;
      end
      stop_test();
   end
endmodule
